// ==== common/wdt_pkg.sv ====
package wdt_pkg;
    // Register byte offsets
    localparam logic [4:0] ADDR_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_KICK = 5'h04;
    localparam logic [4:0] ADDR_STATE = 5'h08;
    localparam logic [4:0] ADDR_COUNT_BYTE0 = 5'h0c;
    localparam logic [4:0] ADDR_COUNT_BYTE1 = 5'h10;
    localparam logic [4:0] ADDR_COUNT_BYTE2 = 5'h14;
    localparam logic [4:0] ADDR_COUNT_BYTE3 = 5'h18;
    localparam int ADDR_W = 5;
    // Control field positions
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_IRQ_FIRST_BIT = 1;
    localparam int CTL_LOCK_BIT = 3;
    localparam int CTL_CODE_LSB = 4;
    localparam int CODE_W = 4;
    // State field positions
    localparam int ST_IRQ_FIRST_LSB = 4;
    localparam int ST_NO_RESET_BIT = 6;
    localparam int ST_IRQ_BIT = 7;
    // Kick magic and period base
    localparam logic [15:0] KICK_MAGIC = 16'h1984;
    localparam int PERIOD_BASE_EXP = 16;
    localparam int COUNT_W = 32;
    // Reset values
    localparam logic [31:0] COUNT_RESET = 32'h0001_0000;
    localparam int RESET_PULSE_CYCLES = 1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control fields as held
    typedef struct packed {
        logic [CODE_W-1:0] period_code;
        logic lock_bit;
        logic irq_first;
        logic run;
    } wdt_ctl_t;

    // Register-write event toward the core
    typedef struct packed {
        logic ctl_we;
        logic [31:0] ctl_wdata;
        logic kick_we;
        logic [31:0] kick_wdata;
    } wdt_wr_t;
endpackage

// ==== hw/wdt_period.sv ====
`timescale 1ns/1ps
// Period code to load value decoder
module wdt_period (
    input wire logic [wdt_pkg::CODE_W-1:0] period_code,
    output logic [wdt_pkg::COUNT_W-1:0] load_value
);
    // Power of two; code 0xf reaches bit 31
    always_comb begin
        load_value = wdt_pkg::COUNT_W'(1) << (wdt_pkg::PERIOD_BASE_EXP + int'(period_code)); // R4
    end
endmodule // wdt_period

// ==== hw/wdt_axil.sv ====
`timescale 1ns/1ps
// AXI4-Lite slave front end; read data comes from the core
module wdt_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output wdt_pkg::wdt_wr_t wr,
    output logic [wdt_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    // Whole slave state
    typedef struct packed {
        logic aw_have;
        logic [wdt_pkg::ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wdt_axs_t;

    wdt_axs_t s_q; // Registered state
    wdt_axs_t s_d; // Next state
    logic do_write; // Both halves held, no response pending
    logic do_read; // Read address accepted

    assign s_awready = !s_q.aw_have && !s_q.bvalid;
    assign s_wready = !s_q.w_have && !s_q.bvalid;
    assign s_arready = !s_q.rvalid;
    assign s_bvalid = s_q.bvalid;
    assign s_bresp = s_q.bresp;
    assign s_rvalid = s_q.rvalid;
    assign s_rdata = s_q.rdata;
    assign s_rresp = s_q.rresp;
    assign rd_addr = s_araddr;
    assign do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign do_read = s_arvalid && s_arready;

    // Write strobes to the core; partial writes are taken whole since
    // the fields of interest all sit in the low half word
    always_comb begin
        wr = '0;
        if (do_write && (s_q.w_strb != 4'h0)) begin
            wr.ctl_we = (s_q.aw_addr == wdt_pkg::ADDR_CONTROL);
            wr.kick_we = (s_q.aw_addr == wdt_pkg::ADDR_KICK);
        end
        wr.ctl_wdata = s_q.w_data;
        wr.kick_wdata = s_q.w_data;
    end

    // Channel bookkeeping
    always_comb begin
        s_d = s_q;
        if (s_awvalid && s_awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_wdata;
            s_d.w_strb = s_wstrb;
        end
        if (do_write) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            // Only control and kick are writable
            s_d.bresp = ((s_q.aw_addr == wdt_pkg::ADDR_CONTROL) ||
                         (s_q.aw_addr == wdt_pkg::ADDR_KICK)) ?
                        wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
        end else if (s_q.bvalid && s_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (do_read) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_data;
            s_d.rresp = rd_hit ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
        end else if (s_q.rvalid && s_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // wdt_axil

// ==== hw/wdt_top.sv ====
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
// Operation
// R1 - Run bit enables decrement and timeouts
// R2 - Magic kick write reloads and restarts count
// R3 - Enable and kick load selected period
// R4 - Load value is two to code plus sixteen
// R5 - Code change waits for kick or reload
// R6 - Lock while running blocks clearing run
// R7 - Lock bit stays set until reset
// R8 - Interrupt-first clear: every timeout resets
// R9 - Interrupt-first: irq first, reset if pending
// R10 - Any reset clears pending interrupt
// R11 - Interrupt output and status flag
// R12 - Count readable as four bytes, low first
// R13 - No interrupt during halt or standby
// R14 - Reserved control bits read zero
// R15 - Seven registers at offsets 0x00 to 0x18
// R16 - Software disables, kicks, then enables
// R17 - Software follows interrupt setup order
// R18 - Decrement once per clock while enabled
// R19 - Count frozen in low power, resumes
// R20 - Valid kick clears pending interrupt
// R21 - Non-magic kick writes ignored
// R22 - Reset request pulse, interrupt held level
module wdt_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic low_power,
    input wire logic por_seen_n,
    output logic wdog_irq,
    output logic wdog_reset_req
);
    ////////////////////////////////////////////////////////////////////////
    // Types and state
    ////////////////////////////////////////////////////////////////////////

    // Core state, one struct
    typedef struct packed {
        wdt_pkg::wdt_ctl_t ctl;
        logic [wdt_pkg::COUNT_W-1:0] count;
        logic irq;
        logic rst_req;
        logic no_reset;
    } wdt_core_t;

    wdt_core_t c_q; // Registered core state
    wdt_core_t c_d; // Next core state
    wdt_pkg::wdt_wr_t wr; // Write events from the bus slave
    logic [wdt_pkg::ADDR_W-1:0] rd_addr; // Read address from bus
    logic [31:0] rd_data; // Read mux result
    logic rd_hit; // Read address is mapped
    logic [wdt_pkg::COUNT_W-1:0] load_value; // Period from code after this cycle's write
    logic kick_ok; // Magic kick this cycle
    logic run_rise; // Run bit goes from clear to set
    logic run_next; // Run bit after this cycle's write
    logic timeout; // Count at zero while running

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    ////////////////////////////////////////////////////////////////////////

    // Bus slave, one write and one read at a time
    wdt_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // Period decoder; fed from the code about to be used on a load
    wdt_period u_period (
        .period_code(c_d.ctl.period_code),
        .load_value(load_value)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read decode
    ////////////////////////////////////////////////////////////////////////

    // Byte of the count, zero-extended to a word
    function automatic logic [31:0] count_byte(input logic [31:0] v, input int idx);
        count_byte = {24'h000000, v[idx*8 +: 8]};
    endfunction

    // Register read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        case (rd_addr) // R15
            wdt_pkg::ADDR_CONTROL: begin
                // Reserved bits 31:8 and 2 read zero
                rd_data[wdt_pkg::CTL_RUN_BIT] = c_q.ctl.run; // R14
                rd_data[wdt_pkg::CTL_IRQ_FIRST_BIT] = c_q.ctl.irq_first;
                rd_data[wdt_pkg::CTL_LOCK_BIT] = c_q.ctl.lock_bit;
                rd_data[wdt_pkg::CTL_CODE_LSB +: wdt_pkg::CODE_W] = c_q.ctl.period_code;
            end
            wdt_pkg::ADDR_KICK: begin
                // Write-only, reads zero
                rd_data = 32'h0000_0000;
            end
            wdt_pkg::ADDR_STATE: begin
                rd_data[wdt_pkg::ST_IRQ_BIT] = c_q.irq; // R11
                rd_data[wdt_pkg::ST_NO_RESET_BIT] = c_q.no_reset;
                rd_data[wdt_pkg::ST_IRQ_FIRST_LSB] = c_q.ctl.irq_first;
                rd_data[wdt_pkg::ST_IRQ_FIRST_LSB+1] = c_q.ctl.irq_first;
            end
            wdt_pkg::ADDR_COUNT_BYTE0: begin
                rd_data = count_byte(c_q.count, 0); // R12
            end
            wdt_pkg::ADDR_COUNT_BYTE1: begin
                rd_data = count_byte(c_q.count, 1); // R12
            end
            wdt_pkg::ADDR_COUNT_BYTE2: begin
                rd_data = count_byte(c_q.count, 2); // R12
            end
            wdt_pkg::ADDR_COUNT_BYTE3: begin
                rd_data = count_byte(c_q.count, 3); // R12
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Core logic
    ////////////////////////////////////////////////////////////////////////

    // Magic value only; anything else is dropped silently
    assign kick_ok = wr.kick_we && (wr.kick_wdata[15:0] == wdt_pkg::KICK_MAGIC); // R2 R21

    // Lock holds the run bit while running
    assign run_next = wr.ctl_we ?
        ((c_q.ctl.lock_bit && c_q.ctl.run) ? 1'b1 : wr.ctl_wdata[wdt_pkg::CTL_RUN_BIT]) :
        c_q.ctl.run; // R6
    assign run_rise = run_next && !c_q.ctl.run;

    // Zero count while enabled and awake counts as a timeout
    assign timeout = c_q.ctl.run && !low_power && (c_q.count == '0); // R1 R13

    // Next state of the core
    always_comb begin
        c_d = c_q;
        c_d.rst_req = 1'b0; // One-cycle request by default
        // Control write; code and first-irq take effect in the held copy
        if (wr.ctl_we) begin
            c_d.ctl.period_code = wr.ctl_wdata[wdt_pkg::CTL_CODE_LSB +: wdt_pkg::CODE_W];
            c_d.ctl.irq_first = wr.ctl_wdata[wdt_pkg::CTL_IRQ_FIRST_BIT];
            // Sticky: a zero written leaves it set
            c_d.ctl.lock_bit = c_q.ctl.lock_bit |
                (wr.ctl_wdata[wdt_pkg::CTL_LOCK_BIT] && run_next); // R7
        end
        c_d.ctl.run = run_next; // R6
        if (run_rise || kick_ok) begin
            // Fresh countdown from the selected period
            c_d.count = load_value; // R3 R2
            if (kick_ok) begin
                c_d.irq = 1'b0; // R20
            end
        end else if (timeout) begin
            // Reload picks up any new code; here is where R5 lands
            c_d.count = load_value; // R5
            if (c_q.ctl.irq_first && !c_q.irq) begin
                c_d.irq = 1'b1; // R9 R13 R22
            end else begin
                c_d.rst_req = 1'b1; // R8 R9 R22
                c_d.no_reset = 1'b0;
            end
        end else if (c_q.ctl.run && !low_power) begin
            c_d.count = c_q.count - 32'h0000_0001; // R18
        end
        // Halt or standby: count simply holds
        // R19
    end

    // Core register; reset clears the interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c_q.ctl <= '0;
            c_q.count <= wdt_pkg::COUNT_RESET;
            c_q.irq <= 1'b0; // R10
            c_q.rst_req <= 1'b0;
            c_q.no_reset <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    assign wdog_irq = c_q.irq; // R11
    assign wdog_reset_req = c_q.rst_req; // R22

    // Strap input unused in this build beyond keeping the port defined
    logic por_unused;
    assign por_unused = por_seen_n;
endmodule // wdt_top

// ==== sim/wdt_top_sva.sv ====
`timescale 1ns/1ps
// Port-level watch on the watchdog; sees only the top ports
module wdt_top_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [wdt_pkg::ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic low_power,
    input wire logic wdog_irq,
    input wire logic wdog_reset_req
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // Handshake steps
    sequence wr_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence rd_taken;
        s_arvalid && s_arready;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_bvalid_holds: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    a_rvalid_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped early");
    a_wr_answer: assert property (wr_taken |-> ##2 s_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (rd_taken |=> s_rvalid)
        else $error("read data late");
    a_rd_unmapped: assert property (rd_taken and s_araddr > wdt_pkg::ADDR_COUNT_BYTE3 |=>
        s_rresp == wdt_pkg::RESP_SLVERR && s_rdata == 32'h0) else $error("unmapped read");
    a_reset_pulse: assert property (wdog_reset_req |=> !wdog_reset_req)
        else $error("reset request too long");
    a_irq_low_power: assert property ($rose(wdog_irq) |-> !$past(low_power))
        else $error("interrupt raised in low power");
    a_rst_low_power: assert property ($rose(wdog_reset_req) |-> !$past(low_power))
        else $error("reset raised in low power");
    // Interrupt may fall only with a write answer or a reset request
    a_irq_level: assert property (wdog_irq |=> wdog_irq || $rose(s_bvalid) || wdog_reset_req)
        else $error("interrupt fell alone");
endmodule // wdt_top_sva

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, low_power;
    logic [4:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, wdog_irq, wdog_reset_req;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    int err_count = 0; // Mismatches
    int n_checks = 0; // Comparisons
    localparam logic [1:0] OK = wdt_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = wdt_pkg::RESP_SLVERR;

    wdt_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .low_power(low_power),
        .por_seen_n(1'b1), .wdog_irq(wdog_irq), .wdog_reset_req(wdog_reset_req));

    // 200 MHz
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ready and valid sampled at the negedge, acted on after the next rise
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        b = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid;
            if (b) chk({30'h0, s_bresp}, {30'h0, er});
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar, r;
        r = 1'b0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!r) begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            r = s_rvalid;
            if (r) chk(s_rdata, e);
            if (r) chk({30'h0, s_rresp}, {30'h0, er});
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
        end
        s_rready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Hang guard, well past the single 2^16 countdown
    initial begin
        repeat (90000) @(posedge aclk);
        err_count++;
        stop_test();
    end

    initial begin
        int p, t;
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, low_power} = '0;
        s_awaddr = '0;
        s_araddr = '0;
        s_wdata = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values; count starts at 2^16
        rd(wdt_pkg::ADDR_CONTROL, 32'h0, OK);
        rd(wdt_pkg::ADDR_STATE, 32'h40, OK);
        for (int i = 0; i < 4; i++) rd(wdt_pkg::ADDR_COUNT_BYTE0 + 5'(4 * i), (i == 2), OK);
        // Reserved bits dropped, run and lock written clear
        wr(wdt_pkg::ADDR_CONTROL, 32'hffff_ff36, OK);
        rd(wdt_pkg::ADDR_CONTROL, 32'h32, OK);
        rd(wdt_pkg::ADDR_STATE, 32'h70, OK);
        wr(5'h1c, 32'h1, ERR);
        rd(5'h1c, 32'h0, ERR);
        wr(wdt_pkg::ADDR_STATE, 32'h1, ERR);
        // Every period code: stale count until kick, bad kick ignored
        for (int c = 0; c < 16; c++) begin
            p = (c == 0) ? 16 : c + 15;
            wr(wdt_pkg::ADDR_CONTROL, 32'(c) << 4, OK);
            wr(wdt_pkg::ADDR_KICK, 32'h1985, OK);
            rd(wdt_pkg::ADDR_COUNT_BYTE0 + 5'(4 * (p / 8)), 32'h1 << (p % 8), OK);
            wr(wdt_pkg::ADDR_KICK, 32'h1984, OK);
            p = c + 16;
            rd(wdt_pkg::ADDR_COUNT_BYTE0 + 5'(4 * (p / 8)), 32'h1 << (p % 8), OK);
        end
        // Enable in low power: period loaded but frozen
        wr(wdt_pkg::ADDR_CONTROL, 32'h0, OK);
        low_power <= 1'b1;
        wr(wdt_pkg::ADDR_CONTROL, 32'h03, OK);
        rd(wdt_pkg::ADDR_COUNT_BYTE2, 32'h01, OK);
        rd(wdt_pkg::ADDR_COUNT_BYTE0, 32'h00, OK);
        chk(wdog_irq, 1'b0);
        low_power <= 1'b0;
        // First timeout raises the interrupt only
        t = 0;
        // Sampled at the falling edge, where the flag has settled
        while (wdog_irq !== 1'b1 && t < 70000) begin
            @(negedge aclk);
            t++;
        end
        chk(wdog_irq, 1'b1);
        chk(wdog_reset_req, 1'b0);
        rd(wdt_pkg::ADDR_STATE, 32'hf0, OK);
        wr(wdt_pkg::ADDR_KICK, 32'h0000_2984, OK);
        chk(wdog_irq, 1'b1);
        wr(wdt_pkg::ADDR_KICK, 32'h1984, OK);
        chk(wdog_irq, 1'b0);
        rd(wdt_pkg::ADDR_STATE, 32'h70, OK);
        // Lock while running: clearing run and lock refused
        wr(wdt_pkg::ADDR_CONTROL, 32'h0b, OK);
        wr(wdt_pkg::ADDR_CONTROL, 32'h0, OK);
        // Interrupt-first stays writable; only run and lock hold
        rd(wdt_pkg::ADDR_CONTROL, 32'h09, OK);
        // Mid-run reset is the only way out of the lock
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(wdt_pkg::ADDR_CONTROL, 32'h0, OK);
        chk(wdog_irq, 1'b0);
        stop_test();
    end
endmodule // tb

bind wdt_top wdt_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .low_power(low_power), .wdog_irq(wdog_irq),
    .wdog_reset_req(wdog_reset_req));
